/* File: hdl/input_status_bank.sv */
`default_nettype none

// Summary of operation
// - bit 3 shows the DoP detector currently holds a valid stream
// - bit 2 sets after a run of good spdif frames, clears on failure
// - bit 1 shows valid frame clock and bit clock on the pcm port
// - bit 0 set only while dsd runs as fallback for pcm and spdif
// - input status is read-only, upper four bits zero, resets to zero
// - 24-bit feedback scale over three read-only bytes, reset zero
module input_status_bank (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ,
   input  wire logic        DOP_LOCK,
   input  wire logic        SPDIF_FRAME_OK,
   input  wire logic        SPDIF_FRAME_BAD,
   input  wire logic        PCM_CLOCKS_OK,
   input  wire logic        DSD_ACTIVE,
   input  wire logic [23:0] FB_SCALE
);

   status_if st ();

   decoder_status_track u_track (
      .clk       (CLK_SYS),
      .rst       (RST),
      .ce        (CE),
      .dop_in    (DOP_LOCK),
      .frame_ok  (SPDIF_FRAME_OK),
      .frame_bad (SPDIF_FRAME_BAD),
      .pcm_in    (PCM_CLOCKS_OK),
      .dsd_in    (DSD_ACTIVE),
      .st        (st)
   );

   status_pkg::apb_state_t state_ff;
   status_pkg::reg_sel_t   sel;

   logic [3:0]  status_ff;
   logic [3:0]  nxt_status;
   logic [3:0]  events;
   logic [3:0]  irq_stat_ff;
   logic [3:0]  nxt_irq_stat;
   logic [3:0]  irq_mask_ff;
   logic [3:0]  nxt_mask;
   logic [3:0]  rd_snap_ff;
   logic [3:0]  rd_clear;
   logic [23:0] fb_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        irq_ff;
   logic        access_req;
   logic        finish;
   logic        mask_wr;

   function automatic status_pkg::reg_sel_t decode(
      input logic [11:0] a
   );
      case (a)
         status_pkg::ADDR_INPUT_STATUS: decode = status_pkg::SEL_STATUS;
         status_pkg::ADDR_FB_SCALE_LO:  decode = status_pkg::SEL_FB_LO;
         status_pkg::ADDR_FB_SCALE_MID: decode = status_pkg::SEL_FB_MID;
         status_pkg::ADDR_FB_SCALE_HI:  decode = status_pkg::SEL_FB_HI;
         status_pkg::ADDR_IRQ_STATUS:   decode = status_pkg::SEL_IRQ_STAT;
         status_pkg::ADDR_IRQ_MASK:     decode = status_pkg::SEL_IRQ_MASK;
         default:                       decode = status_pkg::SEL_NONE;
      endcase
   endfunction

   function automatic logic [31:0] read_word(
      input status_pkg::reg_sel_t s,
      input logic [3:0]           stat,
      input logic [23:0]          fb,
      input logic [3:0]           ist,
      input logic [3:0]           msk
   );
      case (s)
         status_pkg::SEL_STATUS:
            read_word = {24'h0, status_pkg::RSVD_BITS, stat};
         status_pkg::SEL_FB_LO:    read_word = {24'h0, fb[7:0]};
         status_pkg::SEL_FB_MID:   read_word = {24'h0, fb[15:8]};
         status_pkg::SEL_FB_HI:    read_word = {24'h0, fb[23:16]};
         status_pkg::SEL_IRQ_STAT: read_word = {28'h0, ist};
         status_pkg::SEL_IRQ_MASK: read_word = {28'h0, msk};
         default:                  read_word = status_pkg::RDATA_RST;
      endcase
   endfunction

   // first access cycle latches the answer, the second one completes it
   assign sel        = decode(PADDR);
   assign access_req = PSEL && PENABLE && (state_ff == status_pkg::ST_IDLE);
   assign finish     = PSEL && PENABLE && (state_ff == status_pkg::ST_RESP);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_ff <= status_pkg::ST_IDLE;
      end else if (CE) begin
         case (state_ff)
            status_pkg::ST_IDLE: begin
               if (access_req) begin
                  state_ff <= status_pkg::ST_RESP;
               end
            end
            status_pkg::ST_RESP: begin
               state_ff <= status_pkg::ST_IDLE;
            end
            default: begin
               state_ff <= status_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // read data is frozen one cycle before the completing edge, so the
   // interrupt snapshot taken here is exactly what software sees
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         prdata_ff  <= status_pkg::RDATA_RST;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         rd_snap_ff <= 4'h0;
      end else if (CE) begin
         if (access_req) begin
            prdata_ff  <= PWRITE ? status_pkg::RDATA_RST :
                          read_word(sel, status_ff, fb_ff,
                                    irq_stat_ff, irq_mask_ff);
            pready_ff  <= 1'b1;
            pslverr_ff <= (sel == status_pkg::SEL_NONE);
            rd_snap_ff <= irq_stat_ff;
         end else begin
            prdata_ff  <= status_pkg::RDATA_RST;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // decoder flags are sampled every cycle that CE is high, never latched by software
   assign nxt_status = {st.dop_detected,
                        st.spdif_locked,
                        st.pcm_clocks_ok,
                        st.dsd_fallback};

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         status_ff <= status_pkg::STATUS_RST;
      end else if (CE) begin
         status_ff <= nxt_status;
      end
   end

   // feedback scale is a live mirror; writes to its bytes change nothing.
   // the three bytes are separate reads, so a changing value can tear
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         fb_ff <= status_pkg::FB_SCALE_RST;
      end else if (CE) begin
         fb_ff <= FB_SCALE;
      end
   end

   // any change of a decoder flag is an event
   assign events   = nxt_status ^ status_ff;
   assign rd_clear = (finish && !PWRITE &&
                      sel == status_pkg::SEL_IRQ_STAT) ? rd_snap_ff : 4'h0;
   // a new event in the clearing cycle stays set
   assign nxt_irq_stat = (irq_stat_ff & ~rd_clear) | events;

   assign mask_wr  = finish && PWRITE &&
                     sel == status_pkg::SEL_IRQ_MASK && PSTRB[0];
   assign nxt_mask = mask_wr ? PWDATA[3:0] : irq_mask_ff;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_stat_ff <= 4'h0;
      end else if (CE) begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_mask_ff <= status_pkg::IRQ_MASK_RST;
      end else if (CE) begin
         irq_mask_ff <= nxt_mask;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_ff <= 1'b0;
      end else if (CE) begin
         irq_ff <= |(nxt_irq_stat & nxt_mask);
      end
   end

   assign PRDATA  = prdata_ff;
   assign PREADY  = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign IRQ     = irq_ff;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   chk_status_live: assert property (
      CE |=> status_ff == $past(nxt_status))
      else $error("status register lags the decoders");

   chk_dop_path: assert property (
      CE ##1 CE |=> status_ff[status_pkg::BIT_DOP] == $past(DOP_LOCK, 2))
      else $error("dop bit does not reach the register in two cycles");

   chk_pcm_path: assert property (
      CE ##1 CE |=> status_ff[status_pkg::BIT_PCM] == $past(PCM_CLOCKS_OK, 2))
      else $error("pcm bit does not reach the register in two cycles");

   chk_spdif_fail: assert property (
      CE && SPDIF_FRAME_BAD ##1 CE |=> !status_ff[status_pkg::BIT_SPDIF])
      else $error("spdif bit set after a failed frame");

   chk_dsd_excl: assert property (
      status_ff[status_pkg::BIT_DSD] |->
         !status_ff[status_pkg::BIT_PCM] && !status_ff[status_pkg::BIT_SPDIF])
      else $error("dsd bit set beside a working decoder");

   chk_rsvd_zero: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_STATUS
      |=> PREADY && PRDATA[31:4] == 28'h0 && PRDATA[3:0] == $past(status_ff))
      else $error("input status read returns wrong or reserved data");

   chk_fb_ignore: assert property (
      CE && finish && PWRITE && sel == status_pkg::SEL_FB_LO
      |-> !PSLVERR ##1 fb_ff == $past(FB_SCALE))
      else $error("feedback scale write was not ignored");

   chk_apb_answer: assert property (
      CE && access_req |=> PREADY ##1 (!PREADY || !CE))
      else $error("access phase not answered in one cycle");

   chk_fb_mirror: assert property (
      CE |=> fb_ff == $past(FB_SCALE))
      else $error("feedback scale mirror lags its input");

   chk_spdif_path: assert property (
      CE && st.spdif_locked |=> status_ff[status_pkg::BIT_SPDIF])
      else $error("spdif lock does not reach the status register");

   chk_reset_values: assert property (
      $past(RST) |-> status_ff == status_pkg::STATUS_RST && !IRQ &&
         irq_mask_ff == status_pkg::IRQ_MASK_RST && !PREADY &&
         fb_ff == status_pkg::FB_SCALE_RST)
      else $error("register left reset with a nonzero value");

   // a low enable must hold the bus side as well, or a stalled
   // transfer would complete twice
   chk_freeze_state: assert property (
      !CE |=> $stable(status_ff) && $stable(irq_stat_ff) &&
         $stable(irq_mask_ff) && $stable(state_ff) &&
         $stable(IRQ) && $stable(PREADY) && $stable(PRDATA))
      else $error("state moved while the clock enable was low");

   chk_irq_level: assert property (
      CE |=> IRQ == |(irq_stat_ff & irq_mask_ff))
      else $error("interrupt line disagrees with masked status");

   // a change in the clearing cycle must survive the clear
   chk_event_sets: assert property (
      CE && events != 4'h0 |=>
         (irq_stat_ff & $past(events)) == $past(events))
      else $error("decoder change did not set its interrupt bit");

   chk_read_clears: assert property (
      CE && finish && !PWRITE && sel == status_pkg::SEL_IRQ_STAT |=>
         (irq_stat_ff & $past(rd_snap_ff & ~events)) == 4'h0)
      else $error("reported interrupt bit survived its read");

   chk_mask_write: assert property (
      CE && mask_wr |=> irq_mask_ff == $past(PWDATA[3:0]))
      else $error("mask write did not land");

   chk_mask_hold: assert property (
      !(CE && mask_wr) |=> $stable(irq_mask_ff))
      else $error("mask changed without a write");

   chk_unmapped_err: assert property (
      CE && access_req && sel == status_pkg::SEL_NONE |=>
         PREADY && PSLVERR && PRDATA == status_pkg::RDATA_RST)
      else $error("unmapped access not refused");

   chk_idle_quiet: assert property (
      !PREADY |-> PRDATA == status_pkg::RDATA_RST && !PSLVERR)
      else $error("bus outputs active outside the ready cycle");

   chk_write_no_data: assert property (
      CE && access_req && PWRITE |=> PRDATA == status_pkg::RDATA_RST)
      else $error("write returned read data");

   chk_fb_lo_read: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_FB_LO |=>
         PRDATA == {24'h0, $past(fb_ff[7:0])})
      else $error("feedback low byte read wrong");

   chk_fb_mid_read: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_FB_MID |=>
         PRDATA == {24'h0, $past(fb_ff[15:8])})
      else $error("feedback middle byte read wrong");

   chk_fb_hi_read: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_FB_HI |=>
         PRDATA == {24'h0, $past(fb_ff[23:16])})
      else $error("feedback high byte read wrong");

   chk_irq_read: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_IRQ_STAT |=>
         PRDATA == {28'h0, $past(irq_stat_ff)})
      else $error("interrupt status read wrong");

   chk_mask_read: assert property (
      CE && access_req && !PWRITE && sel == status_pkg::SEL_IRQ_MASK |=>
         PRDATA == {28'h0, $past(irq_mask_ff)})
      else $error("interrupt mask read wrong");

   chk_pready_req: assert property (
      $rose(PREADY) |-> $past(PSEL && PENABLE))
      else $error("ready raised without an access phase");

   chk_rsp_state: assert property (
      CE && finish |=> state_ff == status_pkg::ST_IDLE)
      else $error("bus state machine did not return to idle");

endmodule

`default_nettype wire

/* File: common/status_pkg.sv */
`default_nettype none

package status_pkg;

   // register indices; a register sits at byte address index * 4
   localparam int unsigned IDX_INPUT_STATUS = 100;
   localparam int unsigned IDX_FB_SCALE_LO  = 113;
   localparam int unsigned IDX_FB_SCALE_MID = 114;
   localparam int unsigned IDX_FB_SCALE_HI  = 115;
   localparam int unsigned IDX_IRQ_STATUS   = 128;
   localparam int unsigned IDX_IRQ_MASK     = 129;

   localparam logic [11:0] ADDR_INPUT_STATUS = 12'(IDX_INPUT_STATUS * 4);
   localparam logic [11:0] ADDR_FB_SCALE_LO  = 12'(IDX_FB_SCALE_LO * 4);
   localparam logic [11:0] ADDR_FB_SCALE_MID = 12'(IDX_FB_SCALE_MID * 4);
   localparam logic [11:0] ADDR_FB_SCALE_HI  = 12'(IDX_FB_SCALE_HI * 4);
   localparam logic [11:0] ADDR_IRQ_STATUS   = 12'(IDX_IRQ_STATUS * 4);
   localparam logic [11:0] ADDR_IRQ_MASK     = 12'(IDX_IRQ_MASK * 4);

   // bit positions inside input_status and the interrupt registers
   localparam int unsigned BIT_DOP   = 3;
   localparam int unsigned BIT_SPDIF = 2;
   localparam int unsigned BIT_PCM   = 1;
   localparam int unsigned BIT_DSD   = 0;
   localparam int unsigned STATUS_W  = 4;

   localparam logic [3:0]  STATUS_RST   = 4'h0;
   localparam logic [3:0]  RSVD_BITS    = 4'h0;
   localparam logic [23:0] FB_SCALE_RST = 24'h000000;
   localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
   localparam logic [31:0] RDATA_RST    = 32'h00000000;

   // consecutive good frames before the spdif decoder counts as locked
   localparam logic [3:0]  SPDIF_RUN_LEN = 4'h4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESP = 2'b01
   } apb_state_t;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_STATUS,
      SEL_FB_LO,
      SEL_FB_MID,
      SEL_FB_HI,
      SEL_IRQ_STAT,
      SEL_IRQ_MASK
   } reg_sel_t;

endpackage

`default_nettype wire

/* File: common/status_if.sv */
`default_nettype none

interface status_if;
   logic dop_detected;
   logic spdif_locked;
   logic pcm_clocks_ok;
   logic dsd_fallback;

   modport track (
      output dop_detected,
      output spdif_locked,
      output pcm_clocks_ok,
      output dsd_fallback
   );

   modport bank (
      input dop_detected,
      input spdif_locked,
      input pcm_clocks_ok,
      input dsd_fallback
   );
endinterface

`default_nettype wire

/* File: hdl/decoder_status_track.sv */
`default_nettype none

module decoder_status_track (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic dop_in,
   input  wire logic frame_ok,
   input  wire logic frame_bad,
   input  wire logic pcm_in,
   input  wire logic dsd_in,
   status_if.track   st
);

   logic [3:0] run_cnt_ff;
   logic [3:0] nxt_run;
   logic       nxt_spdif;

   // a bad frame drops lock at once; lock needs an unbroken run of good ones
   always_comb begin
      nxt_run   = run_cnt_ff;
      nxt_spdif = st.spdif_locked;
      if (frame_bad) begin
         nxt_run   = 4'h0;
         nxt_spdif = 1'b0;
      end else if (frame_ok && !st.spdif_locked) begin
         if (run_cnt_ff == 4'(status_pkg::SPDIF_RUN_LEN - 4'h1)) begin
            nxt_run   = 4'h0;
            nxt_spdif = 1'b1;
         end else begin
            nxt_run = run_cnt_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         run_cnt_ff      <= 4'h0;
         st.spdif_locked <= 1'b0;
      end else if (ce) begin
         run_cnt_ff      <= nxt_run;
         st.spdif_locked <= nxt_spdif;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st.dop_detected  <= 1'b0;
         st.pcm_clocks_ok <= 1'b0;
         st.dsd_fallback  <= 1'b0;
      end else if (ce) begin
         st.dop_detected  <= dop_in;
         st.pcm_clocks_ok <= pcm_in;
         // dsd only counts while both other decoders have given up
         st.dsd_fallback  <= dsd_in && !pcm_in && !nxt_spdif;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_dop_follow: assert property (
      ce |=> st.dop_detected == $past(dop_in))
      else $error("dop flag does not follow detector");

   chk_spdif_drop: assert property (
      ce && frame_bad |=> !st.spdif_locked)
      else $error("spdif lock survives a bad frame");

   chk_spdif_run: assert property (
      $rose(st.spdif_locked) |-> $past(frame_ok) &&
         $past(run_cnt_ff) == 4'(status_pkg::SPDIF_RUN_LEN - 4'h1))
      else $error("spdif lock without full run of frames");

   chk_dsd_only: assert property (
      st.dsd_fallback |-> !st.pcm_clocks_ok && !st.spdif_locked)
      else $error("dsd flag set while another decoder works");

endmodule

`default_nettype wire

/* File: verification/audio_source_model.sv */
`default_nettype none

module audio_source_model (
   input  wire logic        clk,
   input  wire logic        dop_req,
   input  wire logic        pcm_req,
   input  wire logic        dsd_req,
   input  wire logic        ok_req,
   input  wire logic        bad_req,
   input  wire logic [23:0] fb_req,
   output logic             dop_lock,
   output logic             pcm_ok,
   output logic             dsd_on,
   output logic             frame_ok,
   output logic             frame_bad,
   output logic [23:0]      fb_val
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {dop_lock, pcm_ok, dsd_on, frame_ok, frame_bad} = 5'h00;
      fb_val = 24'h000000;
   end

   // frame strobes last one clock: until lock the decoder counts every enabled cycle that frame_ok is high
   always @(posedge clk) begin
      dop_lock  <= dop_req;
      pcm_ok    <= pcm_req;
      dsd_on    <= dsd_req;
      frame_ok  <= ok_req;
      frame_bad <= bad_req;
      fb_val    <= fb_req;
   end
endmodule

`default_nettype wire

/* File: verification/audio_input_status_readback_bench.sv */
`default_nettype none

module audio_input_status_readback_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        dop_q = 1'b0;
   logic        pcm_q = 1'b0;
   logic        dsd_q = 1'b0;
   logic        ok_q = 1'b0;
   logic        bad_q = 1'b0;
   logic [23:0] fb_q = 24'h000000;
   logic        dop_w, pcm_w, dsd_w, ok_w, bad_w;
   logic [23:0] fb_w;
   logic [31:0] seed = 32'h0000003d;
   logic [31:0] d;
   logic        e;
   int          errors = 0;
   int          checked = 0;
   int          spdif = 0;

   always #12.5 clk = ~clk;

   audio_source_model i_src (.clk(clk), .dop_req(dop_q), .pcm_req(pcm_q),
      .dsd_req(dsd_q), .ok_req(ok_q), .bad_req(bad_q), .fb_req(fb_q),
      .dop_lock(dop_w), .pcm_ok(pcm_w), .dsd_on(dsd_w), .frame_ok(ok_w),
      .frame_bad(bad_w), .fb_val(fb_w));

   input_status_bank i_dut (.CLK_SYS(clk), .RST(rst), .CE(ce),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .DOP_LOCK(dop_w),
      .SPDIF_FRAME_OK(ok_w), .SPDIF_FRAME_BAD(bad_w),
      .PCM_CLOCKS_OK(pcm_w), .DSD_ACTIVE(dsd_w), .FB_SCALE(fb_w));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // live status as the decoders should report it
   function automatic logic [31:0] est();
      logic s;
      s = (spdif >= int'(status_pkg::SPDIF_RUN_LEN));
      return {28'h0000000, dop_q, s, pcm_q, dsd_q & ~pcm_q & ~s};
   endfunction

   task automatic fail(input string m);
      errors++;
      $display("Error %0t: %s", $time, m);
   endtask

   task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) fail($sformatf("data %h expected %h", g, x));
   endtask

   task automatic cmp1(input logic g, input logic x);
      checked++;
      if (g !== x) fail($sformatf("flag %b expected %b", g, x));
   endtask

   // holds the request until pready is sampled high at a rising edge,
   // then releases it right after that edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      d = prdata;
      e = pslverr;
      if (n >= 50) fail("no pready");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h00000000);
      cmp32(d, x);
      cmp1(e, 1'b0);
   endtask

   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   task automatic frame(input logic good);
      @(posedge clk);
      ok_q  <= good;
      bad_q <= ~good;
      @(posedge clk);
      ok_q  <= 1'b0;
      bad_q <= 1'b0;
      spdif = good ? spdif + 1 : 0;
      settle();
   endtask

   task automatic fbchk();
      rchk(status_pkg::ADDR_FB_SCALE_LO, {24'h000000, fb_q[7:0]});
      rchk(status_pkg::ADDR_FB_SCALE_MID, {24'h000000, fb_q[15:8]});
      rchk(status_pkg::ADDR_FB_SCALE_HI, {24'h000000, fb_q[23:16]});
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail("watchdog");
      summarize();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rchk(status_pkg::ADDR_INPUT_STATUS, 32'h00000000);
      fbchk();
      rchk(status_pkg::ADDR_IRQ_MASK, 32'h00000000);
      cmp1(irq, 1'b0);
      $display("reset values done");
      fb_q  <= 24'(xs());
      dop_q <= 1'b1;
      settle();
      apb(1'b1, status_pkg::ADDR_INPUT_STATUS, 32'hffffffff);
      cmp1(e, 1'b0);
      apb(1'b1, status_pkg::ADDR_FB_SCALE_LO, 32'hffffffff);
      cmp1(e, 1'b0);
      rchk(status_pkg::ADDR_INPUT_STATUS, est());
      fbchk();
      apb(1'b0, 12'h300, 32'h00000000);
      cmp1(e, 1'b1);
      cmp32(d, 32'h00000000);
      apb(1'b0, 12'h191, 32'h00000000);
      cmp1(e, 1'b1);
      $display("read-only and unmapped done");
      for (int i = 0; i < 12; i++) begin
         {dop_q, pcm_q, dsd_q} <= 3'(xs());
         fb_q <= 24'(xs());
         settle();
         rchk(status_pkg::ADDR_INPUT_STATUS, est());
         fbchk();
      end
      $display("random levels done");
      pcm_q <= 1'b0;
      dsd_q <= 1'b1;
      settle();
      for (int i = 0; i < 4; i++) begin
         frame(1'b1);
         rchk(status_pkg::ADDR_INPUT_STATUS, est());
      end
      frame(1'b0);
      rchk(status_pkg::ADDR_INPUT_STATUS, est());
      frame(1'b1);
      rchk(status_pkg::ADDR_INPUT_STATUS, est());
      $display("spdif run done");
      apb(1'b1, status_pkg::ADDR_IRQ_MASK, 32'h00000008);
      rchk(status_pkg::ADDR_IRQ_MASK, 32'h00000008);
      apb(1'b0, status_pkg::ADDR_IRQ_STATUS, 32'h00000000);
      repeat (2) @(posedge clk);
      cmp1(irq, 1'b0);
      dop_q <= ~dop_q;
      settle();
      cmp1(irq, 1'b1);
      rchk(status_pkg::ADDR_IRQ_STATUS, 32'h00000008);
      repeat (2) @(posedge clk);
      cmp1(irq, 1'b0);
      pcm_q <= 1'b1;
      settle();
      cmp1(irq, 1'b0);
      rchk(status_pkg::ADDR_IRQ_STATUS, 32'h00000003);
      rchk(status_pkg::ADDR_IRQ_STATUS, 32'h00000000);
      rchk(status_pkg::ADDR_INPUT_STATUS, est());
      $display("interrupt done");
      ce    <= 1'b0;
      dop_q <= ~dop_q;
      settle();
      cmp1(irq, 1'b0);
      ce <= 1'b1;
      settle();
      cmp1(irq, 1'b1);
      rchk(status_pkg::ADDR_INPUT_STATUS, est());
      $display("clock enable done");
      summarize();
   end
endmodule

`default_nettype wire
